/* inc/tpg_defines.svh */
// Register indices, reset values, codes and pin masks for the GPIO bank
`ifndef TPG_DEFINES_SVH
`define TPG_DEFINES_SVH
`define TPG_IDX_C_VALUE 4'h0
`define TPG_IDX_C_DIR 4'h1
`define TPG_IDX_C_STYLE 4'h2
`define TPG_IDX_B_VALUE 4'h4
`define TPG_IDX_B_DIR 4'h5
`define TPG_IDX_B_STYLE 4'h6
`define TPG_IDX_A_VALUE 4'h8
`define TPG_IDX_A_DIR 4'h9
`define TPG_IDX_A_STYLE 4'ha
`define TPG_IDX_POLARITY 4'hc
`define TPG_IDX_PENDING 4'hd
`define TPG_REG_RESET 8'h00
`define TPG_POL_RESET 2'h0
`define TPG_PIN_MASK_C 8'h3f
`define TPG_SYNC_STAGES 2
`endif

/* inc/tpg_pkg.sv */
// Types shared by the GPIO bank
`default_nettype none
package tpg_pkg;
  typedef logic [7:0] tpg_byte_t;
  typedef enum logic [1:0]
  {
    TPG_POL_FALL_LOW = 2'h0,
    TPG_POL_RISE = 2'h1,
    TPG_POL_FALL = 2'h2,
    TPG_POL_BOTH = 2'h3
  } tpg_pol_e;
endpackage : tpg_pkg
`default_nettype wire

/* rtl/tpg_gpio.sv */
// Three-port GPIO bank with Wishbone register access and external interrupt groups
//
// Overview of operation
// [R1] Direction bit: 0 input, 1 output
// [R2] Bit X of each register serves pin X
// [R3] Value read: latch for outputs, pin otherwise
// [R4] Value write always updates the output latch
// [R5] Output pins drive the latched value
// [R6] Every interrupt input pin can raise requests alone
// [R7] Group pin levels ANDed before edge detection
// [R8] Output pins never generate interrupts
// [R9] Peripheral alternate function overrides port settings
// [R10] Peripheral input pins still readable through value
// [R11] Software keeps bidirectional peripheral pins as input
// [R12] Software avoids alternate function on interrupt inputs
// [R13] Software sets analog inputs to floating input
// [R14] Port A: floating/interrupt input, true open-drain
// [R15] Ports B, C: pull-up interrupt, open-drain/push-pull
// [R16] All registers reset to zero, floating inputs
// [R17] Pins without style bit follow direction only
// [R18] Software writes value before switching to output
// [R19] Two-bit polarity code selects edge/level detection
// [R20] Polarity change clears that group's pending request
// [R21] Pin levels pass two synchroniser flip-flops
`include "tpg_defines.svh"
`default_nettype none
module tpg_gpio
  import tpg_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] pin_in_a,
  input wire logic [7:0] pin_in_b,
  input wire logic [5:0] pin_in_c,
  output logic [7:0] pin_out_a,
  output logic [7:0] pin_out_b,
  output logic [5:0] pin_out_c,
  output logic [7:0] pin_oe_n_a,
  output logic [7:0] pin_oe_n_b,
  output logic [5:0] pin_oe_n_c,
  output logic [7:0] pin_pullup_b,
  output logic [5:0] pin_pullup_c,
  input wire logic [7:0] alt_en_a,
  input wire logic [7:0] alt_en_b,
  input wire logic [5:0] alt_en_c,
  input wire logic [7:0] alt_out_a,
  input wire logic [7:0] alt_out_b,
  input wire logic [5:0] alt_out_c,
  input wire logic [7:0] alt_pp_b,
  input wire logic [5:0] alt_pp_c,
  input wire logic [1:0] irq_ack,
  output logic [1:0] irq_req
);

  // ****************************************************************
  // Register storage, index 0 = port A, 1 = B, 2 = C
  // ****************************************************************
  tpg_byte_t port_val [3];
  tpg_byte_t port_dir [3];
  tpg_byte_t port_style [3];
  tpg_pol_e grp_pol [2];
  tpg_byte_t sync1 [3];
  tpg_byte_t sync2 [3];
  logic [1:0] pending;
  logic [1:0] grp_prev;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire logic [3:0] reg_idx = wb_adr_i[5:2];
  wire logic bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire tpg_byte_t wr_byte = wb_dat_i[7:0];
  wire logic wr_val_a = bus_wr & (reg_idx == `TPG_IDX_A_VALUE);
  wire logic wr_val_b = bus_wr & (reg_idx == `TPG_IDX_B_VALUE);
  wire logic wr_val_c = bus_wr & (reg_idx == `TPG_IDX_C_VALUE);
  wire logic wr_dir_a = bus_wr & (reg_idx == `TPG_IDX_A_DIR);
  wire logic wr_dir_b = bus_wr & (reg_idx == `TPG_IDX_B_DIR);
  wire logic wr_dir_c = bus_wr & (reg_idx == `TPG_IDX_C_DIR);
  wire logic wr_sty_a = bus_wr & (reg_idx == `TPG_IDX_A_STYLE);
  wire logic wr_sty_b = bus_wr & (reg_idx == `TPG_IDX_B_STYLE);
  wire logic wr_sty_c = bus_wr & (reg_idx == `TPG_IDX_C_STYLE);
  wire logic wr_pol = bus_wr & (reg_idx == `TPG_IDX_POLARITY);
  wire logic [1:0] pol_new0 = wr_byte[1:0];
  wire logic [1:0] pol_new1 = wr_byte[3:2];
  wire logic [1:0] pol_changed =
    {wr_pol & (pol_new1 != grp_pol[1]), wr_pol & (pol_new0 != grp_pol[0])};

  // ****************************************************************
  // Pin view: absent port C pins read high and never interrupt
  // ****************************************************************
  wire tpg_byte_t raw_pin [3];
  wire tpg_byte_t alt_en [3];
  wire tpg_byte_t alt_out [3];
  wire tpg_byte_t alt_pp [3];
  wire tpg_byte_t present [3];
  assign raw_pin[0] = pin_in_a;
  assign raw_pin[1] = pin_in_b;
  assign raw_pin[2] = {2'h3, pin_in_c};
  assign alt_en[0] = alt_en_a;
  assign alt_en[1] = alt_en_b;
  assign alt_en[2] = {2'h0, alt_en_c};
  assign alt_out[0] = alt_out_a;
  assign alt_out[1] = alt_out_b;
  assign alt_out[2] = {2'h0, alt_out_c};
  // Port A only has true open-drain, so peripherals never push there
  assign alt_pp[0] = 8'h00;
  assign alt_pp[1] = alt_pp_b;
  assign alt_pp[2] = {2'h0, alt_pp_c};
  assign present[0] = 8'hff;
  assign present[1] = 8'hff;
  assign present[2] = `TPG_PIN_MASK_C;

  wire tpg_byte_t dir_eff [3];
  wire tpg_byte_t drv_val [3];
  wire tpg_byte_t push [3];
  wire tpg_byte_t irq_en [3];
  wire tpg_byte_t rd_val [3];
  wire tpg_byte_t next_out [3];
  wire tpg_byte_t next_oe_n [3];
  wire tpg_byte_t next_pull [3];
  tpg_byte_t out_q [3];
  tpg_byte_t oe_n_q [3];
  tpg_byte_t pull_q [3];

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1)
    begin : g_port
      assign dir_eff[p] = port_dir[p] | alt_en[p]; // [R1] [R9]
      assign drv_val[p] = (alt_en[p] & alt_out[p]) | (~alt_en[p] & port_val[p]); // [R5] [R9]
      // Style 1 on port A is reserved and falls back to open-drain
      assign push[p] = (p == 0) ? 8'h00 :
        ((alt_en[p] & alt_pp[p]) | (~alt_en[p] & port_style[p])); // [R14] [R15] [R9]
      assign irq_en[p] = ~dir_eff[p] & port_style[p] & present[p]; // [R6] [R8] [R2]
      assign rd_val[p] = (port_dir[p] & port_val[p]) | (~port_dir[p] & sync2[p]); // [R3] [R10]
      assign next_out[p] = drv_val[p] & dir_eff[p];
      // Open-drain only enables the driver while pulling low
      assign next_oe_n[p] = ~(dir_eff[p] & (push[p] | ~drv_val[p])); // [R14] [R15] [R17]
      assign next_pull[p] = (p == 0) ? 8'h00 : irq_en[p]; // [R14] [R15]

      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          sync1[p] <= 8'hff;
          sync2[p] <= 8'hff;
          out_q[p] <= 8'h00;
          oe_n_q[p] <= 8'hff;
          pull_q[p] <= 8'h00;
        end
        else
        begin
          sync1[p] <= raw_pin[p]; // [R21]
          sync2[p] <= sync1[p]; // [R21]
          out_q[p] <= next_out[p];
          oe_n_q[p] <= next_oe_n[p];
          pull_q[p] <= next_pull[p];
        end
      end
    end
  endgenerate

  assign pin_out_a = out_q[0];
  assign pin_out_b = out_q[1];
  assign pin_out_c = out_q[2][5:0];
  assign pin_oe_n_a = oe_n_q[0];
  assign pin_oe_n_b = oe_n_q[1];
  assign pin_oe_n_c = oe_n_q[2][5:0];
  assign pin_pullup_b = pull_q[1];
  assign pin_pullup_c = pull_q[2][5:0];

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < 3; i++)
      begin
        port_val[i] <= `TPG_REG_RESET; // [R16]
        port_dir[i] <= `TPG_REG_RESET; // [R16]
        port_style[i] <= `TPG_REG_RESET; // [R16]
      end
      grp_pol[0] <= TPG_POL_FALL_LOW;
      grp_pol[1] <= TPG_POL_FALL_LOW;
    end
    else
    begin
      // Value writes land even on input pins so they drive on turnaround
      if (wr_val_a) port_val[0] <= wr_byte; // [R4]
      if (wr_val_b) port_val[1] <= wr_byte; // [R4]
      if (wr_val_c) port_val[2] <= wr_byte; // [R4]
      if (wr_dir_a) port_dir[0] <= wr_byte; // [R1]
      if (wr_dir_b) port_dir[1] <= wr_byte; // [R1]
      if (wr_dir_c) port_dir[2] <= wr_byte; // [R1]
      if (wr_sty_a) port_style[0] <= wr_byte;
      if (wr_sty_b) port_style[1] <= wr_byte;
      if (wr_sty_c) port_style[2] <= wr_byte;
      if (wr_pol)
      begin
        grp_pol[0] <= tpg_pol_e'(pol_new0);
        grp_pol[1] <= tpg_pol_e'(pol_new1);
      end
    end
  end

  // ****************************************************************
  // External interrupt groups: group 0 = port A, group 1 = ports B and C
  // ****************************************************************
  // Disabled pins count as high so they cannot mask the group
  wire logic [1:0] grp_level;
  assign grp_level[0] = &(sync2[0] | ~irq_en[0]); // [R7]
  assign grp_level[1] = &(sync2[1] | ~irq_en[1]) & &(sync2[2] | ~irq_en[2]); // [R7]

  logic [1:0] grp_event;
  always_comb
  begin
    for (int g = 0; g < 2; g++)
    begin
      case (grp_pol[g]) // [R19]
        TPG_POL_FALL_LOW: grp_event[g] = ~grp_level[g];
        TPG_POL_FALL: grp_event[g] = grp_prev[g] & ~grp_level[g];
        TPG_POL_RISE: grp_event[g] = ~grp_prev[g] & grp_level[g];
        TPG_POL_BOTH: grp_event[g] = grp_prev[g] ^ grp_level[g];
        default: grp_event[g] = 1'b0;
      endcase
    end
  end

  // Event beats acknowledge; a polarity change beats both
  wire logic [1:0] next_pending = ~pol_changed & (grp_event | (pending & ~irq_ack)); // [R20]

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pending <= 2'h0;
      grp_prev <= 2'h3;
    end
    else
    begin
      pending <= next_pending; // [R6]
      grp_prev <= grp_level;
    end
  end

  assign irq_req = pending;

  // ****************************************************************
  // Read mux and acknowledge
  // ****************************************************************
  tpg_byte_t rd_mux;
  always_comb
  begin
    case (reg_idx)
      `TPG_IDX_A_VALUE: rd_mux = rd_val[0];
      `TPG_IDX_B_VALUE: rd_mux = rd_val[1];
      `TPG_IDX_C_VALUE: rd_mux = rd_val[2];
      `TPG_IDX_A_DIR: rd_mux = port_dir[0];
      `TPG_IDX_B_DIR: rd_mux = port_dir[1];
      `TPG_IDX_C_DIR: rd_mux = port_dir[2];
      `TPG_IDX_A_STYLE: rd_mux = port_style[0];
      `TPG_IDX_B_STYLE: rd_mux = port_style[1];
      `TPG_IDX_C_STYLE: rd_mux = port_style[2];
      `TPG_IDX_POLARITY: rd_mux = {4'h0, 2'(grp_pol[1]), 2'(grp_pol[0])};
      `TPG_IDX_PENDING: rd_mux = {6'h00, pending};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req & ~wb_we_i) ? {24'h000000, rd_mux} : 32'h0000_0000; // [R3]
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_val_a_write;
    bus_wr && reg_idx == `TPG_IDX_A_VALUE;
  endsequence

  property p_ack_once;
    @(posedge clk) disable iff (reset) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  property p_write_latch;
    @(posedge clk) disable iff (reset) s_val_a_write |=> port_val[0] == $past(wr_byte);
  endproperty
  a_write_latch: assert property (p_write_latch) else $error("value write lost"); // [R4]

  property p_read_value;
    @(posedge clk) disable iff (reset) bus_req && !wb_we_i && reg_idx == `TPG_IDX_B_VALUE
      |=> wb_ack_o && wb_dat_o[7:0] ==
        (($past(port_dir[1]) & $past(port_val[1])) | (~$past(port_dir[1]) & $past(sync2[1])));
  endproperty
  a_read_value: assert property (p_read_value) else $error("value read wrong"); // [R3]

  property p_sync_delay;
    @(posedge clk) disable iff (reset) !$past(reset, 2) |-> sync2[1] == $past(pin_in_b, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync depth wrong"); // [R21]

  property p_drive_push;
    @(posedge clk) disable iff (reset) port_dir[1][0] && port_style[1][0] && !alt_en_b[0]
      |=> !pin_oe_n_b[0] && pin_out_b[0] == $past(port_val[1][0]);
  endproperty
  a_drive_push: assert property (p_drive_push) else $error("push-pull drive wrong"); // [R5]

  property p_a_open_drain;
    @(posedge clk) disable iff (reset) port_dir[0][0] && port_val[0][0] && !alt_en_a[0]
      |=> pin_oe_n_a[0];
  endproperty
  a_a_open_drain: assert property (p_a_open_drain) else $error("port A drove high"); // [R14]

  property p_alt_push;
    @(posedge clk) disable iff (reset) alt_en_c[0] && alt_pp_c[0]
      |=> !pin_oe_n_c[0] && pin_out_c[0] == $past(alt_out_c[0]);
  endproperty
  a_alt_push: assert property (p_alt_push) else $error("alternate override lost"); // [R9]

  property p_output_no_irq;
    @(posedge clk) disable iff (reset) port_dir[0] == 8'hff |-> grp_level[0];
  endproperty
  a_output_no_irq: assert property (p_output_no_irq) else $error("output pin raised irq"); // [R8]

  property p_and_mask;
    @(posedge clk) disable iff (reset) |(irq_en[0] & ~sync2[0]) |-> !grp_level[0];
  endproperty
  a_and_mask: assert property (p_and_mask) else $error("group AND wrong"); // [R7]

  property p_falling;
    @(posedge clk) disable iff (reset) grp_pol[0] == TPG_POL_FALL && $fell(grp_level[0])
      && !pol_changed[0] |=> irq_req[0];
  endproperty
  a_falling: assert property (p_falling) else $error("falling edge missed"); // [R19]

  property p_pol_clear;
    @(posedge clk) disable iff (reset) pol_changed[1] |=> !irq_req[1];
  endproperty
  a_pol_clear: assert property (p_pol_clear) else $error("polarity change kept request"); // [R20]

endmodule // tpg_gpio
`default_nettype wire

/* tb/tpg_board.sv */
// Board-side pad model for one GPIO port
`default_nettype none
module tpg_board #(parameter int W = 8)
(
  input wire logic clk,
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe_n,
  input wire logic [W-1:0] pad_pullup,
  input wire logic [W-1:0] drv_val,
  input wire logic [W-1:0] drv_en,
  output logic [W-1:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] drift = '0;
  // A pad nobody drives wanders, so a missing driver never reads as a lucky constant
  always @(posedge clk)
    drift <= ~drift;
  always_comb
    for (int i = 0; i < W; i++)
      level[i] = !pad_oe_n[i] ? pad_out[i] : drv_en[i] ? drv_val[i] :
        pad_pullup[i] ? 1'b1 : drift[i];
endmodule // tpg_board
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the three-port GPIO bank
`include "tpg_defines.svh"
`default_nettype none
`define CHK(g, e) check_val(8'(g), 8'(e))
module tb
  import tpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [5:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0, rdat;
  logic [7:0] out_a, out_b, oe_a, oe_b, pu_b, in_a, in_b;
  logic [5:0] out_c, oe_c, pu_c, in_c;
  logic [7:0] alt_en_b = '0, alt_out_b = '0, alt_pp_b = '0;
  logic [5:0] alt_en_c = '0, alt_out_c = '0, alt_pp_c = '0;
  logic [7:0] drv_a = '0, drv_b = '0, den_a = 8'hff, den_b = 8'hff;
  logic [5:0] drv_c = '0, den_c = 6'h3f;
  logic [1:0] irq_ack = '0, irq_req;
  int mismatches = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  tpg_gpio DUT (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_in_a(in_a), .pin_in_b(in_b), .pin_in_c(in_c), .pin_out_a(out_a),
    .pin_out_b(out_b), .pin_out_c(out_c), .pin_oe_n_a(oe_a), .pin_oe_n_b(oe_b),
    .pin_oe_n_c(oe_c), .pin_pullup_b(pu_b), .pin_pullup_c(pu_c), .alt_en_a(8'h00),
    .alt_en_b(alt_en_b), .alt_en_c(alt_en_c), .alt_out_a(8'h00), .alt_out_b(alt_out_b),
    .alt_out_c(alt_out_c), .alt_pp_b(alt_pp_b), .alt_pp_c(alt_pp_c), .irq_ack(irq_ack),
    .irq_req(irq_req));
  tpg_board #(.W(8)) board_a (.clk(clk), .pad_out(out_a), .pad_oe_n(oe_a),
    .pad_pullup(8'h00), .drv_val(drv_a), .drv_en(den_a), .level(in_a));
  tpg_board #(.W(8)) board_b (.clk(clk), .pad_out(out_b), .pad_oe_n(oe_b),
    .pad_pullup(pu_b), .drv_val(drv_b), .drv_en(den_b), .level(in_b));
  tpg_board #(.W(6)) board_c (.clk(clk), .pad_out(out_c), .pad_oe_n(oe_c),
    .pad_pullup(pu_c), .drv_val(drv_c), .drv_en(den_c), .level(in_c));
  // ********************************
  // Shared tasks
  // ********************************
  task automatic check_val(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d,
    output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      $display("Error at %0t ns: no bus acknowledge", $time);
    end
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, idx, d, r);
  endtask
  task automatic rd_chk(input logic [3:0] idx, input logic [7:0] e);
    logic [7:0] r;
    wb(1'b0, idx, 8'h00, r);
    `CHK(r, e);
  endtask
  task automatic pulse_ack(input logic [1:0] m);
    @(posedge clk) irq_ack <= m;
    @(posedge clk) irq_ack <= 2'b00;
  endtask
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset();
    logic [3:0] idx [6] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha};
    foreach (idx[i])
      rd_chk(idx[i], `TPG_REG_RESET);
    rd_chk(`TPG_IDX_A_VALUE, 8'h00);
    rd_chk(`TPG_IDX_C_VALUE, 8'hc0);
    `CHK(oe_b, 8'hff);
    `CHK(oe_c, 8'h3f);
    `CHK(pu_b, 8'h00);
    wr(4'h3, 8'hff);
    rd_chk(4'h3, 8'h00);
  endtask
  task automatic t_output();
    @(posedge clk) drv_b <= 8'h3c;
    wr(`TPG_IDX_B_VALUE, 8'ha5);
    rd_chk(`TPG_IDX_B_VALUE, 8'h3c);
    wr(`TPG_IDX_B_STYLE, 8'hff);
    // Value first, then direction, so the pins never glitch
    wr(`TPG_IDX_B_DIR, 8'h0f);
    tick(3);
    `CHK(oe_b, 8'hf0);
    `CHK(out_b & 8'h0f, 8'h05);
    rd_chk(`TPG_IDX_B_VALUE, 8'h35);
    wr(`TPG_IDX_B_STYLE, 8'h00);
    tick(3);
    `CHK(oe_b, 8'hf5);
    wr(`TPG_IDX_A_VALUE, 8'h0f);
    wr(`TPG_IDX_A_STYLE, 8'hff);
    wr(`TPG_IDX_A_DIR, 8'hff);
    tick(3);
    `CHK(oe_a, 8'h0f);
    wr(`TPG_IDX_A_DIR, 8'h00);
    wr(`TPG_IDX_A_STYLE, 8'h00);
  endtask
  task automatic t_alt_pullup();
    // Pin 6 stays an input in software, as peripheral pins must
    alt_en_b <= 8'h40;
    alt_pp_b <= 8'h40;
    alt_en_c <= 6'h01;
    alt_pp_c <= 6'h01;
    alt_out_c <= 6'h01;
    tick(3);
    `CHK(oe_b[6], 1'b0);
    `CHK(out_b[6], 1'b0);
    `CHK(oe_c[0], 1'b0);
    `CHK(out_c[0], 1'b1);
    @(posedge clk) alt_pp_b <= 8'h00;
    alt_out_b <= 8'h40;
    alt_pp_c <= 6'h00;
    tick(3);
    `CHK(oe_b[6], 1'b1);
    `CHK(oe_c[0], 1'b1);
    rd_chk(`TPG_IDX_B_VALUE, 8'h35);
    @(posedge clk) alt_en_b <= 8'h00;
    alt_en_c <= 6'h00;
    wr(`TPG_IDX_C_STYLE, 8'h01);
    // Pad controls settle one edge after the write lands
    tick(1);
    `CHK(pu_c, 8'h01);
    @(posedge clk) den_c <= 6'h3e;
    tick(4);
    rd_chk(`TPG_IDX_C_VALUE, 8'hc1);
    pulse_ack(2'b10);
    tick(2);
    `CHK(irq_req[1], 1'b0);
    @(posedge clk) den_c <= 6'h3f;
    tick(4);
    `CHK(irq_req[1], 1'b1);
    wr(`TPG_IDX_C_STYLE, 8'h00);
    pulse_ack(2'b10);
  endtask
  task automatic t_irq();
    tpg_pol_e codes [4] = '{TPG_POL_FALL_LOW, TPG_POL_RISE, TPG_POL_FALL, TPG_POL_BOTH};
    @(posedge clk) drv_a <= 8'hff;
    tick(3);
    wr(`TPG_IDX_A_STYLE, 8'h01);
    // Drop the request left from the output scenario's turnaround
    pulse_ack(2'b01);
    foreach (codes[i])
    begin
      wr(`TPG_IDX_POLARITY, {6'h0, codes[i]});
      tick(2);
      `CHK(irq_req[0], 1'b0);
      @(posedge clk) drv_a <= 8'hfe;
      tick(4);
      `CHK(irq_req[0], codes[i] != TPG_POL_RISE);
      pulse_ack(2'b01);
      tick(2);
      `CHK(irq_req[0], codes[i] == TPG_POL_FALL_LOW);
      @(posedge clk) drv_a <= 8'hff;
      tick(4);
      `CHK(irq_req[0], codes[i] == TPG_POL_FALL_LOW || codes[i][0]);
    end
    wr(`TPG_IDX_POLARITY, {6'h0, TPG_POL_FALL});
    @(posedge clk) drv_a <= 8'hfd;
    wr(`TPG_IDX_A_STYLE, 8'h03);
    tick(4);
    pulse_ack(2'b01);
    @(posedge clk) drv_a <= 8'hfc;
    tick(4);
    `CHK(irq_req[0], 1'b0);
    @(posedge clk) drv_a <= 8'hff;
    wr(`TPG_IDX_A_VALUE, 8'hff);
    wr(`TPG_IDX_A_DIR, 8'h01);
    tick(4);
    pulse_ack(2'b01);
    @(posedge clk) drv_a <= 8'hfe;
    tick(4);
    `CHK(irq_req[0], 1'b0);
  endtask
  // ********************************
  // Run control
  // ********************************
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    // Whole run is a few hundred cycles; this leaves ample margin
    #50us;
    mismatches++;
    end_of_test();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_output();
    t_alt_pullup();
    t_irq();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
